// *** shared/pin_ctrl_pkg.sv ***
// constants for the five-pin control register block
package pin_ctrl_pkg;
   localparam int NPIN = 5;
   // pin index: 0 = pin23, 1..4 = pin28..pin31
   localparam logic [7:0] OFF_PIN23 = 8'h60;
   localparam logic [7:0] OFF_PIN28 = 8'h74;
   localparam logic [7:0] OFF_PIN29 = 8'h78;
   localparam logic [7:0] OFF_PIN30 = 8'h7c;
   localparam logic [7:0] OFF_PIN31 = 8'h80;
   localparam logic [31:0] CTRL_WMASK = 32'h02f0_7bef;
   localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
   localparam int B_MASK = 25;
   localparam int B_TRIG_HI = 23;
   localparam int B_TRIG_LO = 21;
   localparam int B_DETEN = 20;
   localparam int B_DRV_HI = 14;
   localparam int B_DRV_LO = 12;
   localparam int B_PU_B11 = 11;
   localparam int B_PD_WEAK = 9;
   localparam int B_PU_B8 = 8;
   localparam int B_INEN = 7;
   localparam int B_OUTEN = 6;
   localparam int B_HYST = 5;
   localparam int B_FUNC_HI = 3;
   localparam int B_FUNC_LO = 0;
   localparam logic [2:0] TRIG_RISE = 3'h0;
   localparam logic [2:0] TRIG_FALL = 3'h1;
   localparam logic [2:0] TRIG_BOTH = 3'h2;
   localparam logic [2:0] TRIG_HIGH = 3'h3;
   localparam logic [2:0] TRIG_LOW = 3'h4;
   localparam logic [3:0] FN_GPIO = 4'h0;
   localparam logic [3:0] FN_AUDIO_TX = 4'h5;
   localparam logic [3:0] FN_PWM_CHANNEL_TWO_OUT = 4'h6;
   localparam logic [3:0] FN_SER0_TX = 4'h7;
   localparam logic [3:0] FN_CARD1_CMD = 4'hd;
   localparam logic [3:0] FN_CARD0_D3 = 4'he;
   localparam logic [3:0] FN_CARD0_D0 = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pin_ctrl_pkg

// *** shared/pin_cfg_if.sv ***
// register contents, pending-clear strobe and pending flags shared between slave and pin logic
`timescale 1ns/1ps
interface pin_cfg_if;
   logic [31:0] ctrl [5];
   logic [4:0]  pend_clr;
   logic [4:0]  pend;
   modport regs (output ctrl, output pend_clr, input pend);
   modport pins (input ctrl, input pend_clr, output pend);
endinterface : pin_cfg_if

// *** core/pin_irq_detect.sv ***
// per-pin trigger detection, pending flag and forward gate
`timescale 1ns/1ps
module pin_irq_detect
   import pin_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [31:0] ctrl,
   input  wire logic        pin_in,
   input  wire logic        pend_clr,
   output logic             pend,
   output logic             irq_fwd
);
   logic       last_in;
   logic       next_last_in;
   logic       next_pend;
   logic       next_irq_fwd;
   logic       event_hit;
   logic [2:0] trig;

   always_comb begin
      trig = ctrl[B_TRIG_HI:B_TRIG_LO];
      case (trig)
         TRIG_RISE: event_hit = pin_in & ~last_in;
         TRIG_FALL: event_hit = ~pin_in & last_in;
         TRIG_BOTH: event_hit = pin_in ^ last_in;
         TRIG_HIGH: event_hit = pin_in;
         TRIG_LOW:  event_hit = ~pin_in;
         default:   event_hit = 1'b0;
      endcase
      next_last_in = pin_in;
      // detect disabled: no new pending and no request; a set pending flag holds until cleared
      if (!ctrl[B_DETEN]) begin
         next_pend = pend & ~pend_clr;
         next_irq_fwd = 1'b0;
      end else begin
         // set wins over a clear in the same cycle
         next_pend = event_hit | (pend & ~pend_clr);
         next_irq_fwd = event_hit & ctrl[B_MASK];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_in <= 1'b0;
         pend    <= 1'b0;
         irq_fwd <= 1'b0;
      end else begin
         last_in <= next_last_in;
         pend    <= next_pend;
         irq_fwd <= next_irq_fwd;
      end
   end
endmodule : pin_irq_detect

// *** core/pin_axil_regs.sv ***
// AXI4-Lite slave holding the five pin control registers
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module pin_axil_regs
   import pin_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   pin_cfg_if.regs          cfg
);
   logic [31:0] ctrl [NPIN];
   logic [31:0] next_ctrl [NPIN];
   logic [7:0]  aw_q, next_aw_q;
   logic        aw_have, next_aw_have;
   logic [31:0] w_q, next_w_q;
   logic [3:0]  s_q, next_s_q;
   logic        w_have, next_w_have;
   logic        next_bvalid, next_rvalid;
   logic        next_awready, next_wready, next_arready;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [4:0]  next_clr, clr;
   logic [31:0] bmask;
   int          widx, ridx;

   function automatic int decode(input logic [7:0] a);
      case (a)
         OFF_PIN23: decode = 0;
         OFF_PIN28: decode = 1;
         OFF_PIN29: decode = 2;
         OFF_PIN30: decode = 3;
         OFF_PIN31: decode = 4;
         default:   decode = -1;
      endcase
   endfunction : decode

   assign cfg.pend_clr = clr;
   for (genvar i = 0; i < NPIN; i++) begin : g_out
      assign cfg.ctrl[i] = ctrl[i];
   end

   always_comb begin
      next_ctrl = ctrl;
      next_aw_q = aw_q;
      next_aw_have = aw_have;
      next_w_q = w_q;
      next_s_q = s_q;
      next_w_have = w_have;
      next_bvalid = bvalid & ~bready;
      next_bresp = bresp;
      next_rvalid = rvalid & ~rready;
      next_rresp = rresp;
      next_rdata = rdata;
      next_clr = 5'h0;
      bmask = 32'h0;
      widx = -1;
      ridx = -1;
      if (awvalid && awready) begin
         next_aw_q = awaddr;
         next_aw_have = 1'b1;
      end
      if (wvalid && wready) begin
         next_w_q = wdata;
         next_s_q = wstrb;
         next_w_have = 1'b1;
      end
      if (next_aw_have && next_w_have && !bvalid) begin
         widx = decode({next_aw_q[7:2], 2'b00});
         bmask = {{8{next_s_q[3]}}, {8{next_s_q[2]}},
                  {8{next_s_q[1]}}, {8{next_s_q[0]}}};
         bmask = bmask & CTRL_WMASK;
         if (widx >= 0) begin
            next_ctrl[widx] = (ctrl[widx] & ~bmask) | (next_w_q & bmask);
            // writing the detect-enable bit low drops the pending flag
            next_clr[widx] = bmask[B_DETEN] & ~next_w_q[B_DETEN];
            next_bresp = RESP_OKAY;
         end else begin
            next_bresp = RESP_SLVERR;
         end
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
      end
      if (arvalid && arready) begin
         ridx = decode({araddr[7:2], 2'b00});
         next_rvalid = 1'b1;
         if (ridx >= 0) begin
            next_rdata = ctrl[ridx] & CTRL_WMASK;
            next_rresp = RESP_OKAY;
         end else begin
            next_rdata = 32'h0;
            next_rresp = RESP_SLVERR;
         end
      end
      // readies are flops holding next cycle's idle state, same timing
      next_awready = ~next_aw_have & ~next_bvalid;
      next_wready = ~next_w_have & ~next_bvalid;
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NPIN; i++) begin
            ctrl[i] <= CTRL_RESET;
         end
         aw_q <= 8'h0;
         aw_have <= 1'b0;
         w_q <= 32'h0;
         s_q <= 4'h0;
         w_have <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0;
         clr <= 5'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         aw_q <= next_aw_q;
         aw_have <= next_aw_have;
         w_q <= next_w_q;
         s_q <= next_s_q;
         w_have <= next_w_have;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         clr <= next_clr;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
      end
   end
endmodule : pin_axil_regs

// *** core/pin_ctrl_irq_mux.sv ***
// top: pin control registers, pad controls, trigger detection, pin 23 mux
`timescale 1ns/1ps
module pin_ctrl_irq_mux
   import pin_ctrl_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [4:0]  PAD_IN,
   input  wire logic [4:0]  GPIO_OUT,
   input  wire logic        DIGITAL_AUDIO_TX_OUT,
   input  wire logic        PWM_CHANNEL_TWO_OUT,
   input  wire logic        SERIAL_PORT0_TRANSMIT,
   input  wire logic        CARD_PORT1_COMMAND,
   input  wire logic        CARD_PORT0_DATA3,
   input  wire logic        CARD_PORT0_DATA0,
   output logic [4:0]       PAD_OUT,
   output logic [4:0]       PAD_OE,
   output logic [4:0]       PAD_IE,
   output logic [4:0]       PAD_HYST,
   output logic [14:0]      PAD_DRIVE,
   output logic [4:0]       PAD_PU_10K,
   output logic [4:0]       PAD_PU_50K,
   output logic [4:0]       PAD_PD_100K,
   output logic [19:0]      PAD_FUNC,
   output logic [4:0]       PIN_DATA_IN,
   output logic [4:0]       IRQ_PENDING,
   output logic [4:0]       IRQ_TO_INTERRUPT_CONTROLLER_UNIT
);
   pin_cfg_if cfg ();
   logic [4:0]  irq_fwd;
   logic [4:0]  gated_in;
   logic [4:0]  next_out, next_oe, next_ie, next_hyst;
   logic [4:0]  next_pu10, next_pu50, next_pd, next_din;
   logic [14:0] next_drive;
   logic [19:0] next_func;
   logic        fn_out23;

   pin_axil_regs u_regs (
      .clk     (CORE_CLK),
      .arst_n  (ARST_N),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .cfg     (cfg.regs)
   );

   // a disabled input buffer reads as low to both data and detector
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      assign gated_in[i] = PAD_IN[i] & cfg.ctrl[i][B_INEN];
      pin_irq_detect u_det (
         .clk      (CORE_CLK),
         .arst_n   (ARST_N),
         .ctrl     (cfg.ctrl[i]),
         .pin_in   (gated_in[i]),
         .pend_clr (cfg.pend_clr[i]),
         .pend     (cfg.pend[i]),
         .irq_fwd  (irq_fwd[i])
      );
   end

   always_comb begin
      // peripheral routing for pin 23; unlisted codes drive low
      case (cfg.ctrl[0][B_FUNC_HI:B_FUNC_LO])
         FN_GPIO:      fn_out23 = GPIO_OUT[0];
         FN_AUDIO_TX:  fn_out23 = DIGITAL_AUDIO_TX_OUT;
         FN_PWM_CHANNEL_TWO_OUT:      fn_out23 = PWM_CHANNEL_TWO_OUT;
         FN_SER0_TX:   fn_out23 = SERIAL_PORT0_TRANSMIT;
         FN_CARD1_CMD: fn_out23 = CARD_PORT1_COMMAND;
         FN_CARD0_D3:  fn_out23 = CARD_PORT0_DATA3;
         FN_CARD0_D0:  fn_out23 = CARD_PORT0_DATA0;
         default:      fn_out23 = 1'b0;
      endcase
      for (int i = 0; i < NPIN; i++) begin
         // pins 28..31 route peripherals outside this block
         next_out[i] = (i == 0) ? fn_out23 : GPIO_OUT[i];
         next_oe[i] = cfg.ctrl[i][B_OUTEN];
         next_ie[i] = cfg.ctrl[i][B_INEN];
         next_hyst[i] = cfg.ctrl[i][B_HYST];
         next_pd[i] = cfg.ctrl[i][B_PD_WEAK];
         next_din[i] = gated_in[i];
         next_drive[3*i +: 3] = cfg.ctrl[i][B_DRV_HI:B_DRV_LO];
         next_func[4*i +: 4] = cfg.ctrl[i][B_FUNC_HI:B_FUNC_LO];
         if (i == 0) begin
            next_pu10[i] = cfg.ctrl[i][B_PU_B11];
            next_pu50[i] = cfg.ctrl[i][B_PU_B8];
         end else begin
            next_pu50[i] = cfg.ctrl[i][B_PU_B11];
            next_pu10[i] = cfg.ctrl[i][B_PU_B8];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PAD_OUT <= 5'h0;
         PAD_OE <= 5'h0;
         PAD_IE <= 5'h0;
         PAD_HYST <= 5'h0;
         PAD_DRIVE <= 15'h1249;
         PAD_PU_10K <= 5'h0;
         PAD_PU_50K <= 5'h0;
         PAD_PD_100K <= 5'h0;
         PAD_FUNC <= 20'h0;
         PIN_DATA_IN <= 5'h0;
         IRQ_PENDING <= 5'h0;
         IRQ_TO_INTERRUPT_CONTROLLER_UNIT <= 5'h0;
      end else begin
         PAD_OUT <= next_out;
         PAD_OE <= next_oe;
         PAD_IE <= next_ie;
         PAD_HYST <= next_hyst;
         PAD_DRIVE <= next_drive;
         PAD_PU_10K <= next_pu10;
         PAD_PU_50K <= next_pu50;
         PAD_PD_100K <= next_pd;
         PAD_FUNC <= next_func;
         PIN_DATA_IN <= next_din;
         IRQ_PENDING <= cfg.pend;
         IRQ_TO_INTERRUPT_CONTROLLER_UNIT <= irq_fwd;
      end
   end
endmodule : pin_ctrl_irq_mux

// *** sim/pin_ctrl_chk.sv ***
// port-level assertions for the pin control block
`timescale 1ns/1ps
module pin_ctrl_chk
   import pin_ctrl_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        ARST_N,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [4:0]  PAD_IN,
   input wire logic [4:0]  GPIO_OUT,
   input wire logic [4:0]  PAD_OUT,
   input wire logic [14:0] PAD_DRIVE,
   input wire logic [19:0] PAD_FUNC,
   input wire logic [4:0]  PIN_DATA_IN,
   input wire logic [4:0]  IRQ_PENDING,
   input wire logic [4:0]  IRQ_TO_INTERRUPT_CONTROLLER_UNIT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   a_write_answer: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> S_AXI_BVALID) else $error("write got no response");
   a_bresp_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped early");
   a_read_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read got no data");
   a_rdata_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data not held");
   a_reserved_zero: assert property (
      S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY
      |-> (S_AXI_RDATA & ~CTRL_WMASK) == 32'h0)
      else $error("reserved bits read nonzero");
   a_unmapped_zero: assert property (
      S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
      else $error("unmapped read returned data");
   a_cfg_by_write: assert property (
      $changed({PAD_DRIVE, PAD_FUNC}) |-> $past(S_AXI_BVALID))
      else $error("pad setting changed without a write");
   a_irq_pend: assert property (
      (IRQ_TO_INTERRUPT_CONTROLLER_UNIT & ~IRQ_PENDING) == 5'h0)
      else $error("request without pending flag");
   a_din_gate: assert property (
      (PIN_DATA_IN & ~$past(PAD_IN)) == 5'h0)
      else $error("pin data without pad level");
   a_gpio_out: assert property (
      PAD_OUT[4:1] == $past(GPIO_OUT[4:1]))
      else $error("pad data not following gpio data");
   c_irq: cover property (|IRQ_TO_INTERRUPT_CONTROLLER_UNIT);
   c_pend: cover property (|IRQ_PENDING);
   c_rerr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
   c_berr: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule : pin_ctrl_chk

bind pin_ctrl_irq_mux pin_ctrl_chk u_chk (.CORE_CLK(CORE_CLK),
   .ARST_N(ARST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .PAD_IN(PAD_IN), .GPIO_OUT(GPIO_OUT), .PAD_OUT(PAD_OUT),
   .PAD_DRIVE(PAD_DRIVE), .PAD_FUNC(PAD_FUNC), .PIN_DATA_IN(PIN_DATA_IN),
   .IRQ_PENDING(IRQ_PENDING), .IRQ_TO_INTERRUPT_CONTROLLER_UNIT(IRQ_TO_INTERRUPT_CONTROLLER_UNIT));

// *** sim/pad_irq_model.sv ***
// pads and interrupt sink facing the pin block
`timescale 1ns/1ps
module pad_irq_model (
   input  wire logic       clk,
   input  wire logic [4:0] oe,
   input  wire logic [4:0] dout,
   input  wire logic [4:0] pu,
   input  wire logic [4:0] pd,
   input  wire logic [4:0] ext_en,
   input  wire logic [4:0] ext,
   input  wire logic       irq,
   input  wire logic       cnt_clr,
   output logic      [4:0] pad,
   output int              irq_cnt
);
   logic [4:0] last = 5'h0;
   // a floating pad toggles so no settled level can be mistaken for data
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pad[i] = oe[i] ? dout[i] : ext_en[i] ? ext[i] :
                  pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last[i];
      end
   end
   always_ff @(posedge clk) begin
      last <= pad;
      irq_cnt <= cnt_clr ? 0 : irq_cnt + int'(irq);
   end
endmodule : pad_irq_model

// *** sim/pin_ctrl_irq_mux_bench.sv ***
// register and pad scenarios for the pin control block
`timescale 1ns/1ps
module pin_ctrl_irq_mux_bench;
   import pin_ctrl_pkg::*;
   logic        clk = 0, rst_n = 0, clr = 0;
   logic [7:0]  aw = 0, ar = 0;
   logic [31:0] wd = 0, rd;
   logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic        awr, wrd, bv, arr, rv;
   logic [1:0]  bresp, rresp;
   logic [4:0]  gout = 0, ext = 0, pad, oe, outp, ie, hy, pu10, pu50, pd;
   logic [4:0]  din, pend, irq;
   logic [5:0]  src = 0;
   logic [3:0]  ws = 4'hf;
   logic [14:0] drv;
   logic [19:0] fn;
   int          cnt, fail_count = 0, total_checks = 0;
   logic [7:0]  offs [5] = '{OFF_PIN23, OFF_PIN28, OFF_PIN29, OFF_PIN30,
                             OFF_PIN31};
   logic [3:0]  fc [7] = '{FN_GPIO, FN_AUDIO_TX, FN_PWM_CHANNEL_TWO_OUT, FN_SER0_TX,
                           FN_CARD1_CMD, FN_CARD0_D3, FN_CARD0_D0};
   int          ce [8] = '{1, 1, 2, 0, 0, 0, 0, 0};
   logic [7:0]  p0m = 8'h10, p1m = 8'h1d, p2m = 8'h1f;

   pin_ctrl_irq_mux uut (.CORE_CLK(clk), .ARST_N(rst_n),
      .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .PAD_IN(pad), .GPIO_OUT(gout),
      .DIGITAL_AUDIO_TX_OUT(src[0]), .PWM_CHANNEL_TWO_OUT(src[1]),
      .SERIAL_PORT0_TRANSMIT(src[2]), .CARD_PORT1_COMMAND(src[3]),
      .CARD_PORT0_DATA3(src[4]), .CARD_PORT0_DATA0(src[5]),
      .PAD_OUT(outp), .PAD_OE(oe), .PAD_IE(ie), .PAD_HYST(hy),
      .PAD_DRIVE(drv), .PAD_PU_10K(pu10), .PAD_PU_50K(pu50),
      .PAD_PD_100K(pd), .PAD_FUNC(fn), .PIN_DATA_IN(din),
      .IRQ_PENDING(pend), .IRQ_TO_INTERRUPT_CONTROLLER_UNIT(irq));
   pad_irq_model far (.clk(clk), .oe(oe), .dout(outp), .pu(pu10 | pu50),
      .pd(pd), .ext_en(5'h02), .ext(ext), .irq(irq[1]), .cnt_clr(clr),
      .pad(pad), .irq_cnt(cnt));

   initial forever #12.5 clk = ~clk;

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int   n;
      logic ta, tw;
      ta = 0; tw = 0; n = 0;
      @(posedge clk);
      aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      // address and data may be taken on different edges
      while (!(ta && tw) && n < 100) begin
         @(posedge clk); n++;
         if (awr && !ta) begin ta = 1; awv <= 0; end
         if (wrd && !tw) begin tw = 1; wv <= 0; end
      end
      do begin @(posedge clk); n++; end while (bv !== 1'b1 && n < 100);
      br <= 0;
      if (n >= 100) fail_count++;
      chk("bresp", 32'(er), 32'(bresp));
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      ar <= a; arv <= 1; rr <= 1;
      do begin @(posedge clk); n++; end while (arr !== 1'b1 && n < 100);
      arv <= 0;
      do begin @(posedge clk); n++; end while (rv !== 1'b1 && n < 100);
      rr <= 0;
      if (n >= 100) fail_count++;
      chk("rresp", 32'(er), 32'(rresp));
      chk("rdata", e, rd);
   endtask : rdc
   task automatic setp(input logic v);
      @(posedge clk); ext[1] <= v; repeat (5) @(posedge clk);
   endtask : setp
   task automatic clrc;
      @(posedge clk); clr <= 1; @(posedge clk); clr <= 0;
   endtask : clrc
   task automatic cfg(input logic m, input logic [2:0] t, input logic d);
      wr(OFF_PIN28, {6'h0, m, 1'b0, t, d, 20'h01080}, RESP_OKAY);
   endtask : cfg

   initial begin
      logic [5:0] oh;
      repeat (6) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 5; i++) rdc(offs[i], CTRL_RESET, RESP_OKAY);
      chk("drive", 32'h1249, 32'(drv));
      chk("pads", 32'h0, {2'h0, oe, ie, hy, pd, pu10, pu50});
      chk("func", 32'h0, 32'(fn));
      chk("pins", 32'h0, {12'h0, outp, din, pend, irq});
      rdc(8'h64, 32'h0, RESP_SLVERR);
      wr(8'h84, '1, RESP_SLVERR);
      for (int i = 0; i < 5; i++) wr(offs[i], '1, RESP_OKAY);
      for (int i = 0; i < 5; i++) rdc(offs[i], CTRL_WMASK, RESP_OKAY);
      wr(OFF_PIN29, 32'h800, RESP_OKAY);
      wr(OFF_PIN23, 32'h800, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("pu10", 32'h1b, 32'(pu10));
      chk("pu50", 32'h1e, 32'(pu50));
      chk("drive", 32'h7e38, 32'(drv));
      chk("oe", 32'h1a, 32'(oe));
      chk("ie", 32'h1a, 32'(ie));
      chk("hyst", 32'h1a, 32'(hy));
      chk("pd", 32'h1a, 32'(pd));
      chk("func", 32'hff0f0, 32'(fn));
      rdc(OFF_PIN29, 32'h800, RESP_OKAY);
      // only byte lane 1 may land
      ws <= 4'h2;
      wr(OFF_PIN29, '1, RESP_OKAY);
      ws <= 4'hf;
      rdc(OFF_PIN29, CTRL_WMASK & 32'h0000_ff00, RESP_OKAY);
      gout[3] <= 1;
      repeat (3) @(posedge clk);
      chk("din", 32'h2, 32'(din[3:2]));
      for (int j = 0; j < 7; j++) begin
         wr(OFF_PIN23, 32'h1040 | 32'(fc[j]), RESP_OKAY);
         for (int v = 0; v < 2; v++) begin
            oh = (j == 0) ? 6'h0 : 6'h1 << (j - 1);
            src <= (v == 1) ? oh : ~oh;
            gout[0] <= ((j == 0) == (v == 1));
            repeat (3) @(posedge clk);
            chk("pad_out", 32'(v), 32'(outp[0]));
         end
      end
      cfg(1, TRIG_BOTH, 0);
      clrc;
      setp(1);
      setp(0);
      chk("pend", 32'h0, 32'(pend[1]));
      chk("irq", 32'h0, 32'(cnt));
      cfg(0, TRIG_RISE, 1);
      clrc;
      setp(1);
      chk("pend", 32'h1, 32'(pend[1]));
      chk("din", 32'h1, 32'(din[1]));
      setp(0);
      chk("irq", 32'h0, 32'(cnt));
      for (int c = 0; c < 8; c++) begin
         // park on a reserved code so clearing never races a live level
         cfg(1, 3'h7, 1);
         cfg(1, 3'(c), 0);
         cfg(1, 3'(c), 1);
         repeat (4) @(posedge clk);
         chk("pend0", 32'(p0m[c]), 32'(pend[1]));
         clrc;
         setp(1);
         chk("pend1", 32'(p1m[c]), 32'(pend[1]));
         setp(0);
         chk("pend2", 32'(p2m[c]), 32'(pend[1]));
         repeat (2) @(posedge clk);
         if (c < 3 || c > 4) chk("irq", 32'(ce[c]), 32'(cnt));
         else chk("irq_lvl", 32'h1, 32'(cnt > 1));
      end
      print_verdict;
   end

   initial begin
      #(25 * 8000);
      fail_count++;
      print_verdict;
   end
endmodule : pin_ctrl_irq_mux_bench
